// *** shared/mdio_regs.vh ***
// register map, field positions, reset values and speed formula constants for the motor drive io block
// assumes a 32-bit apb slave with word-aligned registers
`ifndef MDIO_REGS_VH
`define MDIO_REGS_VH

// register byte offsets
`define MDIO_CTRL_ADDR      12'h000
`define MDIO_STATUS_ADDR    12'h004
`define MDIO_IRQ_STAT_ADDR  12'h008
`define MDIO_IRQ_MASK_ADDR  12'h00c
`define MDIO_SPEED_ADDR     12'h010
`define MDIO_DRIVE_ADDR     12'h014

// ctrl fields
`define MDIO_CTRL_FAULT_BIT 0
`define MDIO_CTRL_RESET     32'h0000_0000

// status fields
`define MDIO_ST_ENABLED     0
`define MDIO_ST_FAULT       1
`define MDIO_ST_HALL_MODE   2
`define MDIO_ST_REVERSE     3
`define MDIO_ST_BRAKE       4
`define MDIO_ST_WAIT_TOGGLE 5

// interrupt events
`define MDIO_IRQ_ENABLE     0
`define MDIO_IRQ_DISABLE    1
`define MDIO_IRQ_FAULT      2
`define MDIO_IRQ_BRAKE      3
`define MDIO_IRQ_WIDTH      4

// speed formula constants
`define MDIO_HALL_RPM_K     8'h28
`define MDIO_TACH_RPM_K     8'h3c

`endif

// *** rtl/mdio_top.v ***
// motor drive digital io control: input qualification, enable latch, speed pulse, fault pin
// assumes pclk at 20 mhz, apb master on the same clock, pins asynchronous to pclk
//
// Summary of operation
// - the drive runs only while the enable input is held low and stops whenever it is high.
// - after any interruption or fault the drive stays off until enable goes from high to low.
// - a low direction input negates the signed speed command so the motor turns the other way.
// - a low brake input selects dynamic braking in place of normal drive.
// - in hall mode the speed pulse is the xnor of the three hall inputs.
// - in tach mode the speed pulse is a straight copy of the encoder input.
// - the fault output sinks low while the drive is faulted and is released otherwise.
// - in hall mode rpm equals 40 times the pulse frequency over the pole count.
// - in tach mode rpm equals 60 times the pulse frequency over the encoder line count.
// - feedback mode comes from a setting; present selects hall, absent selects tach.
// - changed settings are taken only on an enable toggle, never while enabled.
`timescale 1ns/1ps
`include "mdio_regs.vh"

module mdio_top (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        clk_en,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        enable_n,
    input  wire        direction_n,
    input  wire        brake_n,
    input  wire [2:0]  hall,
    input  wire        tach_in,
    input  wire        hall_mode_jumper,
    input  wire        drive_fault,
    input  wire [15:0] speed_command_voltage,
    output reg  [15:0] speed_command,
    output reg         drive_on,
    output reg         brake_on,
    output reg         tach_out,
    output reg         fault_out_n,
    output reg         fault_out_oe,
    output reg         irq
);

    // one-hot drive states
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_RUN  = 3'b010;
    localparam [2:0] ST_HOLD = 3'b100;

    // two's complement negate, used for command reversal
    function [15:0] mdio_neg;
        input [15:0] v;
        begin
            mdio_neg = (~v) + 16'h0001;
        end
    endfunction

    // address match for one register, shared by the write decoders and the irq_stat read clear
    function mdio_hit;
        input [11:0] addr;
        input [11:0] offset;
        begin
            mdio_hit = (addr == offset);
        end
    endfunction

    // synchronisers: first stage read only by second stage
    reg  [6:0] sync1;
    reg  [6:0] sync2;
    reg  [2:0] state;
    reg        en_prev;
    reg        hall_mode;
    reg        fault_latched;
    reg        sw_fault;
    reg  [`MDIO_IRQ_WIDTH-1:0] irq_stat;
    reg  [`MDIO_IRQ_WIDTH-1:0] irq_mask;
    reg  [15:0] cmd_q;
    reg  [2:0]  next_state;
    reg         jmp_sync1;
    reg         jmp_sync2;
    reg  [31:0] next_prdata;
    reg         next_pslverr;

    wire en_low   = ~sync2[0];
    wire dir_low  = ~sync2[1];
    wire brk_low  = ~sync2[2];
    wire [2:0] hall_s = sync2[5:3];
    wire tach_s   = sync2[6];
    wire en_fall  = en_prev & ~sync2[0];
    wire fault_now = drive_fault | sw_fault;
    wire rd_acc   = psel & penable & ~pwrite & pready;
    wire wr_acc   = psel & penable & pwrite & pready;

    // sample enable, direction, brake, hall and tach pins to keep them off pclk metastability
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1 <= 7'h7f;
            sync2 <= 7'h7f;
            en_prev <= 1'b1;
        end else if (clk_en) begin
            sync1 <= {tach_in, hall, brake_n, direction_n, enable_n};
            sync2 <= sync1;
            en_prev <= sync2[0];
        end
    end

    // pin latency: a pin edge reaches sync2 after two pclk edges and the outputs after three, drive_on after four;
    // switch inputs are far slower than this, so no debounce is added here
    // the jumper is a pin too; two flops keep a half-set jumper off the mode latch
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            jmp_sync1 <= 1'b0;
            jmp_sync2 <= 1'b0;
        end else if (clk_en) begin
            jmp_sync1 <= hall_mode_jumper;
            jmp_sync2 <= jmp_sync1;
        end
    end

    // drive state: run only after a high-to-low enable edge and while enable stays low
    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (en_fall && !fault_now)
                    next_state = ST_RUN;
            end
            ST_RUN: begin
                if (!en_low)
                    next_state = ST_IDLE;
                else if (fault_now)
                    next_state = ST_HOLD;
            end
            ST_HOLD: begin
                // a fault cannot clear itself by enable staying low
                if (!en_low)
                    next_state = ST_IDLE;
            end
            default: next_state = ST_IDLE;
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_IDLE;
            hall_mode <= 1'b0;
            fault_latched <= 1'b0;
        end else if (clk_en) begin
            state <= next_state;
            // settings taken only on the enable toggle, so jumpers moved mid-run do nothing
            if (en_fall)
                hall_mode <= jmp_sync2;
            if (state == ST_RUN && fault_now)
                fault_latched <= 1'b1;
            else if (state == ST_IDLE && en_fall && !fault_now)
                fault_latched <= 1'b0;
        end
    end

    // command path: the analog word is registered once, then signed by direction
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_q         <= 16'h0000;
            speed_command <= 16'h0000;
        end else if (clk_en) begin
            cmd_q         <= speed_command_voltage;
            // negating the full-scale negative word gives itself; no extra sign bit is kept
            speed_command <= dir_low ? mdio_neg(cmd_q) : cmd_q;
        end
    end

    // drive levels: brake replaces drive only while the state machine runs
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drive_on <= 1'b0;
            brake_on <= 1'b0;
        end else if (clk_en) begin
            drive_on <= (state == ST_RUN) && !brk_low;
            brake_on <= (state == ST_RUN) && brk_low;
        end
    end

    // speed pulse: late by the pipeline only; frequency untouched, rpm = 40f/poles or 60f/lines
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tach_out <= 1'b0;
        end else if (clk_en) begin
            if (hall_mode)
                tach_out <= ~(hall_s[0] ^ hall_s[1] ^ hall_s[2]);
            else
                tach_out <= tach_s;
        end
    end

    // fault pin is open drain: its level is always low, the enable decides if it sinks
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_out_n  <= 1'b0;
            fault_out_oe <= 1'b0;
        end else if (clk_en) begin
            fault_out_n  <= 1'b0;
            fault_out_oe <= fault_latched;
        end
    end

    // event sources for the sticky status bits
    wire [`MDIO_IRQ_WIDTH-1:0] events;
    assign events[`MDIO_IRQ_ENABLE]  = (state != ST_RUN) && (next_state == ST_RUN);
    assign events[`MDIO_IRQ_DISABLE] = (state == ST_RUN) && (next_state == ST_IDLE);
    assign events[`MDIO_IRQ_FAULT]   = (state == ST_RUN) && (next_state == ST_HOLD);
    assign events[`MDIO_IRQ_BRAKE]   = (state == ST_RUN) && brk_low && !brake_on;

    wire rd_irq_stat = rd_acc && mdio_hit(paddr, `MDIO_IRQ_STAT_ADDR);

    // status after this edge; an event in the read cycle wins over the clear
    wire [`MDIO_IRQ_WIDTH-1:0] next_irq_stat =
        (rd_irq_stat ? {`MDIO_IRQ_WIDTH{1'b0}} : irq_stat) | events;

    // sticky status, cleared by reading it; mask and software fault written over apb
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat <= {`MDIO_IRQ_WIDTH{1'b0}};
            irq_mask <= {`MDIO_IRQ_WIDTH{1'b0}};
            sw_fault <= 1'b0;
            irq      <= 1'b0;
        end else if (clk_en) begin
            irq_stat <= next_irq_stat;
            if (wr_acc && mdio_hit(paddr, `MDIO_IRQ_MASK_ADDR))
                irq_mask <= pwdata[`MDIO_IRQ_WIDTH-1:0];
            if (wr_acc && mdio_hit(paddr, `MDIO_CTRL_ADDR))
                sw_fault <= pwdata[`MDIO_CTRL_FAULT_BIT];
            // irq follows the new status, so it never lags a set or a clear by a cycle
            irq      <= |(next_irq_stat & irq_mask);
        end
    end

    // register map seen by software
    //   ctrl      bit 0 software fault, forces a running drive into the faulted state
    //   status    bit 0 running, 1 faulted, 2 hall mode, 3 reversed, 4 braking,
    //             bit 5 faulted and back in idle, waiting for an enable toggle
    //   irq_stat  bit 0 enabled, 1 disabled, 2 fault, 3 brake; a read clears it
    //   irq_mask  same layout as irq_stat
    //   speed     signed speed command after the direction input
    //   drive     bit 0 drive on, 1 brake on, 2 speed pulse
    wire [31:0] status_word = {26'h0000000, state == ST_IDLE && fault_latched,
                               brake_on, dir_low, hall_mode, fault_latched, state == ST_RUN};

    // read mux; unmapped offsets return zero and flag an error
    always @* begin
        next_prdata  = 32'h0000_0000;
        next_pslverr = 1'b0;
        case (paddr)
            `MDIO_CTRL_ADDR:     next_prdata = {31'h00000000, sw_fault};
            `MDIO_STATUS_ADDR:   next_prdata = status_word;
            `MDIO_IRQ_STAT_ADDR: next_prdata = {28'h0000000, irq_stat | events};
            `MDIO_IRQ_MASK_ADDR: next_prdata = {28'h0000000, irq_mask};
            `MDIO_SPEED_ADDR:    next_prdata = {16'h0000, speed_command};
            `MDIO_DRIVE_ADDR:    next_prdata = {29'h00000000, tach_out, brake_on, drive_on};
            default:             next_pslverr = 1'b1;
        endcase
    end

    // apb slave: no wait state, pready rises in the first access cycle
    // read data is captured at setup so it stands through the whole access cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (clk_en) begin
            pready  <= psel & ~penable;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            if (psel && !penable) begin
                pslverr <= next_pslverr;
                prdata  <= next_prdata;
            end
        end
    end

endmodule // mdio_top

// *** sim/mdio_assertions.sv ***
// timing checks on the pins and apb answer of mdio_top
// assumes the bench holds every control pin steady for several cycles
`timescale 1ns/1ps
module mdio_chk (
    input wire       pclk,
    input wire       presetn,
    input wire       psel,
    input wire       penable,
    input wire       pready,
    input wire       pslverr,
    input wire       enable_n,
    input wire       drive_fault,
    input wire       drive_on,
    input wire       fault_out_n,
    input wire       fault_out_oe,
    input wire [2:0] hall,
    input wire       tach_in,
    input wire       hall_mode_jumper,
    input wire       tach_out
);
    reg mode_q;
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // mode at the last enable fall; the design latches later, before drive_on rises
    always @(posedge pclk)
        if ($fell(enable_n))
            mode_q <= hall_mode_jumper;
    AST_APB_ANSWER: assert property (psel && !penable |=> pready) else $error("no answer");
    AST_ERR_READY: assert property (pslverr |-> pready) else $error("error without ready");
    AST_FAULT_SINK: assert property (fault_out_n == 1'b0) else $error("pin level");
    AST_FAULT_SET: assert property (drive_fault && drive_on |-> ##[1:4] fault_out_oe)
        else $error("fault pin not sinking");
    AST_FAULT_STOP: assert property (fault_out_oe [*3] |-> !drive_on)
        else $error("running while faulted");
    AST_DISABLE: assert property (enable_n [*5] |-> !drive_on)
        else $error("running with enable high");
    AST_RUN_FALL: assert property ($rose(drive_on) |-> !$past(enable_n) && !$past(enable_n, 2))
        else $error("run without enable low");
    AST_PULSE: assert property (drive_on && $stable(mode_q) |->
        tach_out == (mode_q ? ~^$past(hall, 3) : $past(tach_in, 3))) else $error("bad pulse");
endmodule // mdio_chk
bind mdio_top mdio_chk i_mdio_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
    .pslverr(pslverr), .enable_n(enable_n), .drive_fault(drive_fault), .drive_on(drive_on),
    .fault_out_n(fault_out_n), .fault_out_oe(fault_out_oe), .hall(hall), .tach_in(tach_in),
    .hall_mode_jumper(hall_mode_jumper), .tach_out(tach_out));

// *** sim/mdio_motor.sv ***
// rotor sensor model: six-step hall code and encoder pulses while spin is high
// assumes the bench drives spin; a stopped rotor holds its code
`timescale 1ns/1ps
module mdio_motor (
    input  wire       pclk,
    input  wire       spin,
    output reg  [2:0] hall,
    output reg        tach
);
    reg [1:0] cnt = 2'h0;
    initial hall = 3'h1;
    initial tach = 1'h0;
    // pull-ups keep a stopped rotor's code steady, so holding is realistic
    always @(posedge pclk)
        if (spin) begin
            cnt <= cnt + 2'h1;
            tach <= ~tach;
            if (cnt == 2'h3)
                hall <= {hall[1:0], ~hall[2]};
        end
endmodule // mdio_motor

// *** sim/mdio_top_tb.sv ***
// self-checking bench for mdio_top with the rotor model
// assumes the checker binds itself to mdio_top
`timescale 1ns/1ps
`include "mdio_regs.vh"
module mdio_top_tb;
    reg         pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    reg         clk_en = 1'h1, enable_n = 1'h1, direction_n = 1'h1, brake_n = 1'h1;
    reg         hall_mode_jumper = 1'h1, drive_fault = 1'h0, spin = 1'h1, err;
    reg  [11:0] paddr = 12'h0;
    reg  [31:0] pwdata = 32'h0, rd, rnd;
    reg  [15:0] speed_command_voltage = 16'h0;
    wire [31:0] prdata;
    wire [15:0] speed_command;
    wire [2:0]  hall;
    wire        pready, pslverr, tach_in, tach_out, drive_on, brake_on;
    wire        fault_out_n, fault_out_oe, irq;
    integer     err_count = 0, compares = 0, seed = 32'ha790, i;
    mdio_top i_mdio_top (
        .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .enable_n(enable_n), .direction_n(direction_n), .brake_n(brake_n),
        .hall(hall), .tach_in(tach_in), .hall_mode_jumper(hall_mode_jumper),
        .drive_fault(drive_fault), .speed_command_voltage(speed_command_voltage),
        .speed_command(speed_command), .drive_on(drive_on), .brake_on(brake_on),
        .tach_out(tach_out), .fault_out_n(fault_out_n), .fault_out_oe(fault_out_oe), .irq(irq));
    mdio_motor i_mdio_motor (.pclk(pclk), .spin(spin), .hall(hall), .tach(tach_in));
    initial forever #25 pclk = ~pclk;
    function [15:0] exp_speed(input [15:0] v, input d);
        exp_speed = d ? v : 16'h0 - v;
    endfunction
    task chk(input string what, input [31:0] exp, input [31:0] got);
        compares = compares + 1;
        if (got !== exp) begin
            err_count = err_count + 1;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task give_verdict;
        $display("compares %0d errors %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // request held until pready is sampled high, then one idle cycle
    task apb(input w, input [11:0] a, input [31:0] d);
        integer n;
        {psel, pwrite, paddr, pwdata} <= {1'h1, w, a, d};
        @(posedge pclk);
        penable <= 1'h1;
        for (n = 0; n < 20 && pready !== 1'h1; n = n + 1)
            @(posedge pclk);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'h0;
        if (n == 20) begin
            err_count = err_count + 1;
            give_verdict;
        end
        @(posedge pclk);
    endtask
    task run_is(input exp);
        integer n;
        for (n = 0; n < 20 && drive_on !== exp; n = n + 1)
            @(posedge pclk);
        chk("drive_on", exp, drive_on);
        if (n == 20)
            give_verdict;
    endtask
    task pause;
        repeat (8) @(posedge pclk);
    endtask
    task toggle;
        enable_n <= 1'h1;
        pause;
        enable_n <= 1'h0;
    endtask
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        // reset value, a refused place, then run with only the fault unmasked
        apb(1'h0, `MDIO_CTRL_ADDR, 32'h0);
        chk("ctrl", `MDIO_CTRL_RESET, rd);
        apb(1'h1, 12'h0f0, 32'h1);
        chk("slverr", 32'h1, err);
        apb(1'h1, `MDIO_IRQ_MASK_ADDR, 32'h4);
        toggle;
        run_is(1'h1);
        // random commands both ways, the most negative value first
        for (i = 0; i < 8; i = i + 1) begin
            rnd = $random(seed);
            speed_command_voltage <= (i == 0) ? 16'h8000 : rnd[15:0];
            direction_n <= i[0];
            pause;
            chk("speed", exp_speed(speed_command_voltage, direction_n), speed_command);
        end
        brake_n <= 1'h0;
        pause;
        chk("brake", 32'h1, brake_on);
        chk("irq", 32'h0, irq);
        brake_n <= 1'h1;
        $display("run tests done");
        // rotor stopped so the pulse is static; the new setting waits for a toggle
        spin <= 1'h0;
        hall_mode_jumper <= 1'h0;
        pause;
        chk("xnor", ~^hall, tach_out);
        toggle;
        run_is(1'h1);
        chk("copy", tach_in, tach_out);
        spin <= 1'h1;
        $display("mode tests done");
        // fault: pin sinks, drive stays off until a fresh enable fall
        apb(1'h0, `MDIO_IRQ_STAT_ADDR, 32'h0);
        drive_fault <= 1'h1;
        pause;
        drive_fault <= 1'h0;
        chk("fault_pin", 32'h1, fault_out_oe);
        chk("irq", 32'h1, irq);
        apb(1'h0, `MDIO_IRQ_STAT_ADDR, 32'h0);
        chk("irq_stat", 32'h4, rd & 32'h4);
        run_is(1'h0);
        toggle;
        chk("irq", 32'h0, irq);
        run_is(1'h1);
        chk("fault_pin", 32'h0, fault_out_oe);
        enable_n <= 1'h1;
        run_is(1'h0);
        $display("fault tests done");
        // clock enable low freezes all state, so the enable fall counts only once it returns
        clk_en <= 1'h0;
        enable_n <= 1'h0;
        pause;
        chk("frozen", 32'h0, drive_on);
        clk_en <= 1'h1;
        run_is(1'h1);
        $display("freeze tests done");
        give_verdict;
    end
endmodule // mdio_top_tb
